/* File: core/bhp_pkg.sv */
/*
 * shared constants of the byte-wide host port: bus widths, the address
 * window of the asynchronous-packet fifo, and the strobe timing that the
 * host end generates.
 * assumes: both ends and the interface are compiled after this package.
 */
`default_nettype none

package bhp_pkg;

    // bus widths
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;

    // fifo window: addresses at or above this reach the packet fifo
    localparam logic [8:0] FIFO_BASE = 9'h1f0;

    // level a released data bus reads as
    localparam logic [7:0] BUS_IDLE = 8'hff;

    // host strobe timing, in cycles of clk_i (200 MHz)
    localparam int CNT_W = 4;
    localparam logic [3:0] SETUP_CYCLES = 4'h1;
    localparam logic [3:0] STROBE_CYCLES = 4'h8;
    localparam logic [3:0] RECOVER_CYCLES = 4'h4;

    // reset values
    localparam logic [8:0] ADDR_RST = 9'h000;
    localparam logic [7:0] DATA_RST = 8'h00;

endpackage : bhp_pkg

`default_nettype wire

/* File: core/bhp_host_if.sv */
/*
 * the host port wires between the device end and the host end.
 * assumes: one clock for both ends; the interface resolves the shared data
 * bus and the open-drain interrupt line with a pull-up level when undriven.
 */
`timescale 1ns/1ps
`default_nettype none

interface bhp_host_if;
    logic host_select_n;
    logic host_write_strobe_n;
    logic host_read_strobe_n;
    logic [8:0] host_address_bus;
    // data bus: one output and enable per end, one resolved level
    logic [7:0] host_data_host;
    logic host_data_host_oe;
    logic [7:0] host_data_dev;
    logic host_data_dev_oe;
    logic [7:0] host_data_bus;
    // open-drain interrupt: output, enable, resolved level
    logic host_irq_n_out;
    logic host_irq_n_oe;
    logic host_irq_n;

    // device has priority only to keep the level defined on contention
    assign host_data_bus = host_data_dev_oe ? host_data_dev :
                           host_data_host_oe ? host_data_host :
                           bhp_pkg::BUS_IDLE;
    // pull-up supplies the high level
    assign host_irq_n = host_irq_n_oe ? host_irq_n_out : 1'b1;

    modport dev (
        input host_select_n,
        input host_write_strobe_n,
        input host_read_strobe_n,
        input host_address_bus,
        input host_data_bus,
        output host_data_dev,
        output host_data_dev_oe,
        output host_irq_n_out,
        output host_irq_n_oe
    );

    modport host (
        output host_select_n,
        output host_write_strobe_n,
        output host_read_strobe_n,
        output host_address_bus,
        output host_data_host,
        output host_data_host_oe,
        input host_data_bus,
        input host_irq_n
    );
endinterface : bhp_host_if

`default_nettype wire

/* File: core/bhp_dev_end.sv */
/*
 * device end of the byte-wide host port: turns host select and strobes into
 * single-cycle register and fifo access pulses and drives read data back.
 * assumes: the internal side answers a read pulse with acc_rdata_i in the
 * same cycle; host pins are synchronous inputs to clk_i.
 * timing: a pin change reaches the request decode after two edges, the
 * access pulse stands one cycle after the third edge, and read data is
 * driven from the fourth edge until the read request ends.
 * the host must hold address and write data stable from before its
 * strobe falls until the strobe rises: both are taken at the
 * synchronised leading edge, not when the strobe ends.
 * a strobe must go inactive, or select high, for at least one cycle
 * between two accesses; a strobe held low is one access, not many.
 * the interrupt pin mirrors irq_pending_i one cycle late; a sticky cause
 * register, if wanted, lives behind the access pulses.
 * the data bus and interrupt line are resolved in the carrier interface,
 * which also supplies the pull-up level of the open-drain line.
 */
// Behaviour
// RULE1 - eight-bit two-way data bus, bit 7 msb
// RULE2 - nine-bit address decoded to select location
// RULE3 - access allowed only while select is low
// RULE4 - write strobe with select means write
// RULE5 - read strobe, select, write high drives data
// RULE6 - both strobes low performs write, no read
// RULE7 - single r/w host: line to write, read low
// RULE8 - irq low while pending; host reads cause
// RULE9 - interrupt open drain, pulled up when idle
// RULE10 - low reset clears device asynchronously
// RULE11 - port serves registers and asynchronous packet fifo
// RULE12 - synchronise select and strobes, one write each
`timescale 1ns/1ps
`default_nettype none

module bhp_dev_end (
    input wire logic clk_i,
    input wire logic resetn_i,
    bhp_host_if.dev bus,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic fifo_wr_o,
    output logic fifo_rd_o,
    output logic [8:0] acc_addr_o,
    output logic [7:0] acc_wdata_o,
    input wire logic [7:0] acc_rdata_i,
    input wire logic irq_pending_i
);

    // true when an address falls in the packet fifo window
    function automatic logic bhp_is_fifo(input logic [8:0] addr);
        bhp_is_fifo = (addr >= bhp_pkg::FIFO_BASE);
    endfunction : bhp_is_fifo

    // write request: select and write strobe both low
    function automatic logic bhp_wr_decode(input logic sel_n,
                                           input logic wr_n);
        bhp_wr_decode = !sel_n && !wr_n;
    endfunction : bhp_wr_decode

    // read request: select low, read low and no write strobe over it
    function automatic logic bhp_rd_decode(input logic sel_n,
                                           input logic wr_n,
                                           input logic rd_n);
        bhp_rd_decode = !sel_n && wr_n && !rd_n;
    endfunction : bhp_rd_decode

    typedef struct packed {
        // two-stage synchronisers, stage one read only by stage two
        logic sel_s1;
        logic sel_s2;
        logic wr_s1;
        logic wr_s2;
        logic rd_s1;
        logic rd_s2;
        // request seen last cycle, for edge detection
        logic wr_seen;
        logic rd_seen;
        // access pulses and their target
        logic wr_p;
        logic rd_p;
        logic to_fifo;
        logic [8:0] addr;
        // write data holds between writes; reads leave it untouched
        logic [7:0] wdata;
        // read data driven to the host
        logic [7:0] dout;
        logic doe;
        logic irq_oe;
    } bhp_dev_state_t;

    // registered state and the value it takes at the next edge
    bhp_dev_state_t st_ff;
    bhp_dev_state_t nxt_st;

    // requests as decoded from the second synchroniser stage
    logic wr_req;
    logic rd_req;

    // decoded requests from synchronised pins only
    always_comb
    begin
        // select gates everything
        wr_req = bhp_wr_decode(st_ff.sel_s2,
                               st_ff.wr_s2);  // see RULE3 see RULE4
        // a low write strobe overrides the read strobe
        rd_req = bhp_rd_decode(st_ff.sel_s2, st_ff.wr_s2,
                               st_ff.rd_s2);  // see RULE5 see RULE6 see RULE7
    end

    // next-state logic
    always_comb
    begin
        // every field holds unless a branch below changes it
        nxt_st = st_ff;

        // select and strobe pins pass two flops before anything looks at them
        nxt_st.sel_s1 = bus.host_select_n;  // see RULE12
        nxt_st.sel_s2 = st_ff.sel_s1;
        nxt_st.wr_s1 = bus.host_write_strobe_n;
        nxt_st.wr_s2 = st_ff.wr_s1;
        nxt_st.rd_s1 = bus.host_read_strobe_n;
        nxt_st.rd_s2 = st_ff.rd_s1;

        // edge history; pulses default low so each lasts one cycle
        nxt_st.wr_seen = wr_req;
        nxt_st.rd_seen = rd_req;
        nxt_st.wr_p = 1'b0;
        nxt_st.rd_p = 1'b0;

        // one write pulse per strobe assertion, on its leading edge
        if (wr_req && !st_ff.wr_seen)
        begin
            nxt_st.wr_p = 1'b1;  // see RULE12 see RULE4
            // address and data are held stable by the host by now
            nxt_st.addr = bus.host_address_bus;  // see RULE2
            nxt_st.wdata = bus.host_data_bus;  // see RULE1
            nxt_st.to_fifo = bhp_is_fifo(bus.host_address_bus);  // see RULE11
        end
        else if (rd_req && !st_ff.rd_seen)
        begin
            // one read pulse, so a fifo pop happens once per strobe
            nxt_st.rd_p = 1'b1;  // see RULE5
            nxt_st.addr = bus.host_address_bus;  // see RULE2
            nxt_st.to_fifo = bhp_is_fifo(bus.host_address_bus);  // see RULE11
        end

        // latch the answer the cycle after the read pulse
        if (st_ff.rd_p && rd_req)
        begin
            nxt_st.dout = acc_rdata_i;
            nxt_st.doe = 1'b1;  // see RULE5
        end
        // release as soon as the read ends or turns into a write
        if (!rd_req)
        begin
            nxt_st.doe = 1'b0;  // see RULE6 see RULE3
        end

        // drive the open-drain line only while an interrupt is pending
        // pending level is from this clock domain: no synchroniser
        nxt_st.irq_oe = irq_pending_i;  // see RULE8 see RULE9
    end

    // state register; reset needs no clock edge
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            // sync stages idle high so reset release is no access
            st_ff.sel_s1 <= 1'b1;  // see RULE10
            st_ff.sel_s2 <= 1'b1;
            st_ff.wr_s1 <= 1'b1;
            st_ff.wr_s2 <= 1'b1;
            st_ff.rd_s1 <= 1'b1;
            st_ff.rd_s2 <= 1'b1;
            // no access pending and no pulse out
            st_ff.wr_seen <= 1'b0;
            st_ff.rd_seen <= 1'b0;
            st_ff.wr_p <= 1'b0;
            st_ff.rd_p <= 1'b0;
            st_ff.to_fifo <= 1'b0;
            st_ff.addr <= bhp_pkg::ADDR_RST;
            st_ff.wdata <= bhp_pkg::DATA_RST;
            // pins let go: data bus undriven, interrupt line released
            st_ff.dout <= bhp_pkg::DATA_RST;
            st_ff.doe <= 1'b0;
            st_ff.irq_oe <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // pulses split by target window
    assign reg_wr_o = st_ff.wr_p && !st_ff.to_fifo;
    assign fifo_wr_o = st_ff.wr_p && st_ff.to_fifo;  // see RULE11
    assign reg_rd_o = st_ff.rd_p && !st_ff.to_fifo;
    assign fifo_rd_o = st_ff.rd_p && st_ff.to_fifo;
    // target stays until the next access, so late sampling is safe
    assign acc_addr_o = st_ff.addr;
    assign acc_wdata_o = st_ff.wdata;

    // pin drivers; data bus from flops, interrupt only ever pulls low
    assign bus.host_data_dev = st_ff.dout;  // see RULE1
    assign bus.host_data_dev_oe = st_ff.doe;
    assign bus.host_irq_n_out = 1'b0;  // see RULE9
    assign bus.host_irq_n_oe = st_ff.irq_oe;

endmodule : bhp_dev_end

`default_nettype wire

/* File: core/bhp_host_end.sv */
/*
 * host end of the byte-wide host port: runs one select/strobe cycle per
 * user request and returns read data.
 * assumes: the device end answers reads within the strobe time; with
 * SINGLE_RW set the host behaves as a single read/write-line cpu.
 */
`timescale 1ns/1ps
`default_nettype none

module bhp_host_end #(
    parameter bit SINGLE_RW = 1'b0
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    bhp_host_if.host bus,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [8:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic irq_o
);

    typedef enum logic [1:0] {
        H_IDLE,
        H_SETUP,
        H_STROBE,
        H_RECOVER
    } bhp_host_phase_t;

    typedef struct packed {
        bhp_host_phase_t phase;
        logic [3:0] cnt;
        logic write;
        logic sel_n;
        logic wr_n;
        logic rd_n;
        logic [8:0] addr;
        logic [7:0] wdata;
        logic doe;
        logic [7:0] rdata;
        logic done;
    } bhp_host_state_t;

    bhp_host_state_t st_ff;
    bhp_host_state_t nxt_st;

    // next-state logic of the access sequencer
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.cnt = st_ff.cnt - 4'h1;
        case (st_ff.phase)
            H_IDLE:
            begin
                if (req_i)
                begin
                    nxt_st.phase = H_SETUP;
                    nxt_st.cnt = bhp_pkg::SETUP_CYCLES;
                    nxt_st.write = req_write_i;
                    nxt_st.addr = req_addr_i;
                    nxt_st.wdata = req_wdata_i;
                    nxt_st.sel_n = 1'b0;  // see RULE3
                    nxt_st.doe = req_write_i;
                    // r/w line settles with select so no false read
                    nxt_st.wr_n = SINGLE_RW ? !req_write_i : 1'b1; // see RULE7
                end
            end
            H_SETUP:
            begin
                if (st_ff.cnt == 4'h1)
                begin
                    nxt_st.phase = H_STROBE;
                    nxt_st.cnt = bhp_pkg::STROBE_CYCLES;
                    if (!SINGLE_RW)
                    begin
                        nxt_st.wr_n = !st_ff.write;
                        nxt_st.rd_n = st_ff.write;
                    end
                end
            end
            H_STROBE:
            begin
                if (st_ff.cnt == 4'h1)
                begin
                    nxt_st.phase = H_RECOVER;
                    nxt_st.cnt = bhp_pkg::RECOVER_CYCLES;
                    if (!st_ff.write)
                    begin
                        nxt_st.rdata = bus.host_data_bus;
                    end
                    if (!SINGLE_RW)
                    begin
                        nxt_st.wr_n = 1'b1;
                        nxt_st.rd_n = 1'b1;
                    end
                end
            end
            H_RECOVER:
            begin
                // with split strobes, recovery lets the device see the strobe end
                if (st_ff.cnt == 4'h1)
                begin
                    nxt_st.phase = H_IDLE;
                    nxt_st.sel_n = 1'b1;
                    nxt_st.wr_n = 1'b1;
                    nxt_st.doe = 1'b0;
                    nxt_st.done = 1'b1;
                end
            end
            default:
            begin
                nxt_st.phase = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_ff.phase <= H_IDLE;
            st_ff.cnt <= 4'h0;
            st_ff.write <= 1'b0;
            st_ff.sel_n <= 1'b1;
            st_ff.wr_n <= 1'b1;
            // single r/w cpu keeps the read strobe tied low
            st_ff.rd_n <= !SINGLE_RW;  // see RULE7
            st_ff.addr <= bhp_pkg::ADDR_RST;
            st_ff.wdata <= bhp_pkg::DATA_RST;
            st_ff.doe <= 1'b0;
            st_ff.rdata <= bhp_pkg::DATA_RST;
            st_ff.done <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign busy_o = (st_ff.phase != H_IDLE);
    assign done_o = st_ff.done;
    assign rdata_o = st_ff.rdata;
    assign irq_o = !bus.host_irq_n;  // see RULE8

    assign bus.host_select_n = st_ff.sel_n;
    assign bus.host_write_strobe_n = st_ff.wr_n;
    assign bus.host_read_strobe_n = st_ff.rd_n;
    assign bus.host_address_bus = st_ff.addr;
    assign bus.host_data_host = st_ff.wdata;
    assign bus.host_data_host_oe = st_ff.doe;

endmodule : bhp_host_end

`default_nettype wire

/* File: tb/bhp_port_properties.sv */
/* checker of the wires between host end and device end.
 * assumes: one clock domain; fed from the first interface by name. */
`timescale 1ns/1ps
`default_nettype none

module bhp_port_properties (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic host_select_n,
    input wire logic host_write_strobe_n,
    input wire logic host_read_strobe_n,
    input wire logic [8:0] host_address_bus,
    input wire logic host_data_dev_oe,
    input wire logic host_irq_n_out,
    input wire logic host_irq_n_oe,
    input wire logic host_irq_n
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // request kinds as seen on the pins
    sequence s_rd;
        !host_select_n && host_write_strobe_n && !host_read_strobe_n;
    endsequence
    sequence s_wr;
        !host_select_n && !host_write_strobe_n;
    endsequence

    AST_READ_DRIVES:
        assert property (s_rd [*5] |-> host_data_dev_oe)
        else $error("device silent during read");
    AST_WRITE_NO_DRIVE:
        assert property (s_wr [*4] |-> !host_data_dev_oe)
        else $error("device drives bus during write");
    AST_UNSEL_NO_DRIVE:
        assert property (host_select_n [*4] |-> !host_data_dev_oe)
        else $error("device drives bus while deselected");
    AST_OE_CAUSE:
        assert property ($rose(host_data_dev_oe) |-> !$past(host_select_n, 3)
            && $past(host_write_strobe_n, 3)
            && !$past(host_read_strobe_n, 3))
        else $error("bus driven without a read request");
    AST_IRQ_OPEN_DRAIN:
        assert property (host_irq_n_oe |-> !host_irq_n_out && !host_irq_n)
        else $error("interrupt driven high");
    AST_IRQ_PULLUP:
        assert property (!host_irq_n_oe |-> host_irq_n)
        else $error("released interrupt line not high");
    AST_RESET_QUIET:
        assert property ($rose(resetn_i) |-> !host_data_dev_oe
            && !host_irq_n_oe)
        else $error("outputs active just after reset");
    AST_STROBE_SELECTED:
        assert property (!(host_write_strobe_n && host_read_strobe_n)
            |-> !host_select_n)
        else $error("strobe without select");
    AST_ADDR_HELD:
        assert property (!host_select_n && !$past(host_select_n)
            |-> $stable(host_address_bus))
        else $error("address moved during access");
endmodule : bhp_port_properties

`default_nettype wire

/* File: tb/byte_wide_host_register_port_tb_top.sv */
/* testbench: a dual strobe pair and a single r/w line pair, scoreboard on
 * device access pulses and host read data.
 * assumes: package, interface and both ends are compiled first. */
`timescale 1ns/1ps
`default_nettype none

module byte_wide_host_register_port_tb_top;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [1:0] req_i = '0;
    logic [1:0] req_write_i = '0;
    logic [1:0][8:0] req_addr_i = '0;
    logic [1:0][7:0] req_wdata_i = '0;
    logic [1:0] irq_pending_i = '0;
    wire [1:0] busy_o;
    wire [1:0] done_o;
    wire [1:0] irq_o;
    wire [1:0][7:0] rdata_o;
    wire [1:0][7:0] acc_wdata_o;
    wire [1:0][8:0] acc_addr_o;
    wire [1:0][3:0] pulse;
    logic [20:0] note_q [2][$];
    logic [8:0] rd_q [2][$];
    logic [8:0] addr_tbl [4] = '{9'h000, 9'h1ef, 9'h1f0, 9'h1ff};
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 32'hcc94_647b;
    logic [31:0] r;

    always #2.5 clk_i = ~clk_i;

    // pair 0 splits strobes, pair 1 is a single r/w line cpu
    for (genvar m = 0; m < 2; m++)
    begin : g_mode
        bhp_host_if bus_if ();
        bhp_dev_end bhp_dev_end_inst (
            .clk_i(clk_i),
            .resetn_i(resetn_i),
            .bus(bus_if.dev),
            .reg_wr_o(pulse[m][0]),
            .reg_rd_o(pulse[m][1]),
            .fifo_wr_o(pulse[m][2]),
            .fifo_rd_o(pulse[m][3]),
            .acc_addr_o(acc_addr_o[m]),
            .acc_wdata_o(acc_wdata_o[m]),
            .acc_rdata_i(acc_addr_o[m][7:0] ^ 8'h5a),
            .irq_pending_i(irq_pending_i[m])
        );
        bhp_host_end #(.SINGLE_RW(m == 1)) bhp_host_end_inst (
            .clk_i(clk_i),
            .resetn_i(resetn_i),
            .bus(bus_if.host),
            .req_i(req_i[m]),
            .req_write_i(req_write_i[m]),
            .req_addr_i(req_addr_i[m]),
            .req_wdata_i(req_wdata_i[m]),
            .busy_o(busy_o[m]),
            .done_o(done_o[m]),
            .rdata_o(rdata_o[m]),
            .irq_o(irq_o[m])
        );
    end

    bhp_port_properties bhp_port_properties_inst (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .host_select_n(g_mode[0].bus_if.host_select_n),
        .host_write_strobe_n(g_mode[0].bus_if.host_write_strobe_n),
        .host_read_strobe_n(g_mode[0].bus_if.host_read_strobe_n),
        .host_address_bus(g_mode[0].bus_if.host_address_bus),
        .host_data_dev_oe(g_mode[0].bus_if.host_data_dev_oe),
        .host_irq_n_out(g_mode[0].bus_if.host_irq_n_out),
        .host_irq_n_oe(g_mode[0].bus_if.host_irq_n_oe),
        .host_irq_n(g_mode[0].bus_if.host_irq_n)
    );

    task automatic check(input logic [20:0] seen, input logic [20:0] exp,
                         input string what);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report;
        if (n_mismatch == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    // one host request; notes go in before the pins move
    task automatic access(input int m, input logic wr, input logic [8:0] a,
                          input logic [7:0] d);
        logic fifo;
        int waited;
        logic [20:0] span;
        fifo = (a >= bhp_pkg::FIFO_BASE);
        span = 21'(bhp_pkg::SETUP_CYCLES) + 21'(bhp_pkg::STROBE_CYCLES)
               + 21'(bhp_pkg::RECOVER_CYCLES);
        note_q[m].push_back({4'b0001 << {fifo, ~wr}, a, wr ? d : 8'h00});
        rd_q[m].push_back({~wr, a[7:0] ^ 8'h5a});
        @(negedge clk_i);
        req_i[m] = 1'b1;
        req_write_i[m] = wr;
        req_addr_i[m] = a;
        req_wdata_i[m] = d;
        @(negedge clk_i);
        req_i[m] = 1'b0;
        check({20'h0, busy_o[m]}, 21'h1, "busy");
        // done stands one cycle: look at every falling edge until it shows
        waited = 0;
        while (waited < 40 && done_o[m] !== 1'b1)
        begin
            @(negedge clk_i);
            waited++;
        end
        check({20'h0, done_o[m]}, 21'h1, "done");
        check(21'(waited), span, "cycles");
        check({20'h0, busy_o[m]}, 21'h0, "idle");
    endtask : access

    // scoreboard: a pulse or a completion takes the oldest note; looked at
    // mid-cycle, where registered outputs have settled
    always @(negedge clk_i)
    begin
        logic [20:0] seen;
        logic [20:0] exp;
        logic [8:0] rexp;
        for (int m = 0; m < 2; m++)
        begin
            if (pulse[m] !== 4'h0)
            begin
                exp = note_q[m].size() > 0 ? note_q[m].pop_front() : 21'h0;
                seen = {pulse[m], acc_addr_o[m], 8'h00};
                if (pulse[m][0] | pulse[m][2])
                    seen[7:0] = acc_wdata_o[m];
                check(seen, exp, "acc");
            end
            if (done_o[m] === 1'b1)
            begin
                rexp = rd_q[m].size() > 0 ? rd_q[m].pop_front() : 9'h0;
                if (rexp[8])
                begin
                    seen = {13'h0, rdata_o[m]};
                    exp = {13'h0, rexp[7:0]};
                    check(seen, exp, "rdata");
                end
            end
        end
    end

    initial
    begin
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        // edges of the fifo window on both pairs
        for (int m = 0; m < 2; m++)
            foreach (addr_tbl[i])
            begin
                access(m, 1'b1, addr_tbl[i], 8'ha5 ^ 8'(i));
                access(m, 1'b0, addr_tbl[i], 8'h00);
            end
        repeat (24)
        begin
            r = $random(seed);
            access(int'(r[31]), r[30], r[8:0], r[16:9]);
        end
        for (int m = 0; m < 2; m++)
        begin
            irq_pending_i[m] = 1'b1;
            repeat (2) @(negedge clk_i);
            check({20'h0, irq_o[m]}, 21'h1, "irq raised");
            irq_pending_i[m] = 1'b0;
            repeat (2) @(negedge clk_i);
            check({20'h0, irq_o[m]}, 21'h0, "irq cleared");
        end
        // reset off the clock edge must release the line at once
        irq_pending_i = 2'b11;
        repeat (2) @(negedge clk_i);
        #1 resetn_i = 1'b0;
        #1 check({20'h0, irq_o[0]}, 21'h0, "irq in reset");
        @(negedge clk_i);
        irq_pending_i = 2'b00;
        resetn_i = 1'b1;
        access(0, 1'b1, 9'h0ff, 8'h3c);
        access(0, 1'b0, 9'h0ff, 8'h00);
        // a missing pulse or completion leaves a note behind
        @(negedge clk_i);
        for (int m = 0; m < 2; m++)
        begin
            check(21'(note_q[m].size()), 21'h0, "notes left");
            check(21'(rd_q[m].size()), 21'h0, "reads left");
        end
        final_report();
    end

    // watchdog: the run needs well under 4000 cycles
    initial
    begin
        #20000;
        n_mismatch++;
        final_report();
    end
endmodule : byte_wide_host_register_port_tb_top

`default_nettype wire
